// ### verilog/tmc_mode_ctrl.sv
// Summary of operation
// RULE1: six modes from two select pins, supplies, temperature and wakes; code sets mode from timers, not temperature
// RULE2: mode_select high, standby_select_n high gives normal, power on
// RULE3: mode_select low, standby_select_n high gives silent, driver off
// RULE4: go-to-sleep held for sleep_entry_delay enters sleep, power released
// RULE5: both pins low give standby, receiver off, power kept on
// RULE6: in standby a pending wake request drives receive_out low
// RULE7: in normal mode fault_indicator_n reports the wake source
// RULE8: entering normal clears wake request and power-up flags
// RULE9: expiry timer starts in standby, clears on entering normal
// RULE10: silent entered from standby keeps expiry timer running into sleep
// RULE11: expiry timer elapsing without normal selected forces sleep
// RULE12: undervoltage timers armed only after supply first rises
// RULE13: armed undervoltage timer running past dwell time forces sleep
// RULE14: after ordinary sleep, standby_select_n rise wakes, mode_select picks
// RULE15: pin wake from sleep needs I/O supply above rising threshold
// RULE16: after timer sleep, mode_select edge with standby_select_n high wakes
// RULE17: controller toggles mode_select with standby_select_n low first
// RULE18: standby_select_n then held low for standby_low_hold_time
// RULE19: sleep turns off driver, receiver and system power output
// RULE20: sleep exits on bus wake pattern, local wake or pin rise
// RULE21: pending wake events keep device in standby instead of sleep
// RULE22: silent mode shows power-up and local failure on fault output
// RULE23: bus wake is dominant, recessive, dominant, each filtered, in timeout
// RULE24: local wake fires on either edge of local_trigger_pin
// RULE25: all timers are counters with configurable terminal counts
`include "tmc_params.svh"
`default_nettype none
module tmc_mode_ctrl #(
   parameter int unsigned GTS_CYC      = 32'(`TMC_GTS_CYC),
   parameter int unsigned UV_CYC       = 32'(`TMC_UV_CYC),
   parameter int unsigned INACTIVE_CYC = 32'(`TMC_INACTIVE_CYC),
   parameter int unsigned HOLD_CYC     = 32'(`TMC_HOLD_CYC),
   parameter int unsigned WK_FILT_CYC  = 32'(`TMC_WK_FILT_CYC),
   parameter int unsigned WK_TMO_CYC   = 32'(`TMC_WK_TMO_CYC)
) (
   input  wire logic                   clock,             // 40 MHz
   input  wire logic                   nrst,              // sync reset
   input  wire logic                   mode_select,       // pin
   input  wire logic                   standby_select_n,  // pin
   input  wire logic                   bus_dominant,      // low-power rx
   input  wire logic                   local_trigger_pin, // wake pin
   input  wire logic                   supply_ok,         // main supply
   input  wire logic                   core_above_rise,   // core comp
   input  wire logic                   core_below_fall,   // core comp
   input  wire logic                   io_above_rise,     // i/o comp
   input  wire logic                   io_below_fall,     // i/o comp
   input  wire logic                   over_temp,         // local failure
   input  wire logic [`TMC_ADDR_W-1:0] reg_addr,          // byte address
   input  wire logic [31:0]            reg_wdata,         // write data
   input  wire logic                   reg_wr,            // write strobe
   input  wire logic                   reg_rd,            // read strobe
   output logic      [31:0]            reg_rdata,         // next cycle
   output tmc_pkg::tmc_mode_t          mode,              // current mode
   output logic                        driver_enable,     // transmitter
   output logic                        receiver_enable,   // main rx
   output logic                        receive_out,       // rx pin
   output logic                        system_power_out,  // power pin
   output logic                        system_power_oe,   // power drive
   output logic                        fault_indicator_n, // fault pin
   output logic                        wakeup_request_flag, // pending
   output logic                        power_up_flag      // power-up
);
   import tmc_pkg::*;

   // ************************************************************
   // input synchronisers
   // ************************************************************
   localparam int NSYNC = 10;
   logic [NSYNC-1:0] pin_raw, sync_a, sync_b, sync_d;
   assign pin_raw = {over_temp, supply_ok, core_above_rise, core_below_fall,
                     io_above_rise, io_below_fall, local_trigger_pin,
                     bus_dominant, standby_select_n, mode_select};
   // every pin goes through three stages; the first is read by nothing else
   genvar gi;
   for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clock) begin
         sync_a[gi] <= nrst ? pin_raw[gi] : 1'b0;
         sync_b[gi] <= nrst ? sync_a[gi] : 1'b0;
         sync_d[gi] <= nrst ? sync_b[gi] : 1'b0;
      end
   end
   wire ms       = sync_b[0];
   wire stb      = sync_b[1];
   wire bus_dom  = sync_b[2];
   wire sup      = sync_b[8];
   wire tsd      = sync_b[9];
   wire core_rf  = sync_b[7];
   wire core_lo  = sync_b[6];
   wire io_ok    = sync_b[5];
   wire io_lo    = sync_b[4];
   wire ms_edge  = ms ^ sync_d[0];
   wire ms_rise  = ms & ~sync_d[0];
   wire stb_rise = stb & ~sync_d[1];
   wire loc_edge = sync_b[3] ^ sync_d[3];                       // RULE24

   // ************************************************************
   // register port
   // ************************************************************
   tmc_mode_t state, next_state;
   logic [1:0]  cfg;
   logic [1:0]  wake_src;
   logic        sleep_by_timer;
   wire sel_cfg = reg_addr == `TMC_OFS_CONFIG;
   wire sel_st  = reg_addr == `TMC_OFS_STATUS;
   wire [31:0] status_word = {23'h0, sleep_by_timer, wake_src,
                              power_up_flag, wakeup_request_flag, 1'b0, state};
   wire [31:0] next_rdata = !reg_rd ? 32'h0 :
                            sel_cfg ? {30'h0, cfg} :
                            sel_st  ? status_word : 32'h0;
   // config steers the wake detectors; unmapped reads give zero
   always_ff @(posedge clock) begin
      reg_rdata <= nrst ? next_rdata : 32'h0;
      if (!nrst) begin
         cfg <= `TMC_CFG_RESET;
      end else if (reg_wr && sel_cfg) begin
         cfg <= reg_wdata[1:0];
      end
   end

   // ************************************************************
   // wake detectors
   // ************************************************************
   tmc_wake_t wk_ph;
   logic [31:0] filt_cnt, tmo_cnt;
   logic        bus_wake, local_wake;
   wire wake_active = state inside {TMC_STANDBY, TMC_GOTOSLEEP, TMC_SLEEP};
   wire want_dom    = wk_ph != TMC_WK_REC;
   wire filt_hit    = (bus_dom == want_dom) && filt_cnt >= WK_FILT_CYC;
   wire tmo_hit     = wk_ph != TMC_WK_IDLE && tmo_cnt >= WK_TMO_CYC;
   wire bus_wake_in = wake_active && cfg[`TMC_CFG_BUS_WAKE_EN] &&
                      wk_ph == TMC_WK_DOM2 && filt_hit && !tmo_hit;
   wire loc_wake_in = wake_active && cfg[`TMC_CFG_LOC_WAKE_EN] && loc_edge;
   // wrong bus state restarts the filter but never the sequence itself
   always_ff @(posedge clock) begin
      if (!nrst || !wake_active || tmo_hit) begin
         wk_ph    <= TMC_WK_IDLE;                               // RULE23
         filt_cnt <= 32'h0;
         tmo_cnt  <= 32'h0;
      end else begin
         filt_cnt <= (bus_dom != want_dom || filt_hit) ? 32'h0 :
                     filt_cnt + 32'h1;
         tmo_cnt  <= wk_ph == TMC_WK_IDLE ? 32'h0 : tmo_cnt + 32'h1;
         if (filt_hit) begin
            unique case (wk_ph)
               TMC_WK_IDLE: wk_ph <= TMC_WK_REC;                // RULE23
               TMC_WK_REC:  wk_ph <= TMC_WK_DOM2;
               TMC_WK_DOM2: wk_ph <= TMC_WK_IDLE;
            endcase
         end
      end
      bus_wake   <= nrst & bus_wake_in;
      local_wake <= nrst & loc_wake_in;                         // RULE24
   end

   // ************************************************************
   // timers
   // ************************************************************
   logic [31:0] gts_cnt, swe_cnt, hold_cnt, core_cnt, io_cnt;
   logic        swe_run, core_arm, io_arm, prep_done;
   wire gts_done  = state == TMC_GOTOSLEEP && gts_cnt >= GTS_CYC; // RULE4
   wire swe_done  = swe_run && swe_cnt >= INACTIVE_CYC &&
                    state inside {TMC_STANDBY, TMC_SILENT};      // RULE10 RULE11
   wire uv_done   = (core_arm && core_cnt >= UV_CYC) ||
                    (io_arm && io_cnt >= UV_CYC);               // RULE13
   wire hold_done = hold_cnt >= HOLD_CYC;                       // RULE18
   // each counter is a plain up-counter against a parameter terminal count
   always_ff @(posedge clock) begin
      if (!nrst) begin
         gts_cnt  <= 32'h0;
         swe_cnt  <= 32'h0;
         swe_run  <= 1'b0;
         core_arm <= 1'b0;                                      // RULE12
         io_arm   <= 1'b0;
         core_cnt <= 32'h0;
         io_cnt   <= 32'h0;
      end else begin
         gts_cnt  <= state == TMC_GOTOSLEEP ? gts_cnt + 32'h1 : 32'h0; // RULE25
         core_arm <= core_arm | core_rf;                        // RULE12
         io_arm   <= io_arm | io_ok;
         core_cnt <= (core_arm && core_lo && state != TMC_SLEEP) ?
                     core_cnt + 32'h1 : 32'h0;                  // RULE13
         io_cnt   <= (io_arm && io_lo && state != TMC_SLEEP) ?
                     io_cnt + 32'h1 : 32'h0;
         if (state == TMC_NORMAL || state == TMC_SLEEP ||
             state == TMC_OFF) begin
            swe_run <= 1'b0;                                    // RULE9
            swe_cnt <= 32'h0;
         end else if (state == TMC_STANDBY && !swe_run) begin
            swe_run <= 1'b1;                                    // RULE9
            swe_cnt <= 32'h0;
         end else if (swe_run) begin
            swe_cnt <= swe_cnt + 32'h1;                         // RULE10
         end
      end
   end

   // preparation before a timer-caused sleep may be left by the pins
   always_ff @(posedge clock) begin
      if (!nrst || state != TMC_SLEEP) begin
         hold_cnt  <= 32'h0;
         prep_done <= 1'b0;
      end else if (stb) begin
         hold_cnt  <= 32'h0;
      end else if (ms_edge) begin
         hold_cnt  <= 32'h0;                                    // RULE17
         prep_done <= 1'b0;
      end else begin
         hold_cnt  <= hold_done ? hold_cnt : hold_cnt + 32'h1;
         prep_done <= prep_done | (hold_done & (sync_d[1] == 1'b0)); // RULE18
      end
   end

   // ************************************************************
   // mode state machine
   // ************************************************************
   logic     wake_pend;
   wire      any_wake = bus_wake | local_wake;
   assign    wake_pend = wakeup_request_flag | any_wake;
   // a pending wake turns every would-be sleep into standby
   wire tmc_mode_t sleep_tgt = wake_pend ? TMC_STANDBY : TMC_SLEEP; // RULE21
   tmc_mode_t pin_mode;
   // a pending wake also refuses go-to-sleep, else standby would bounce
   assign pin_mode = stb ? (ms ? TMC_NORMAL : TMC_SILENT) :     // RULE2 RULE3
                     (ms & ~wake_pend ? TMC_GOTOSLEEP :         // RULE4 RULE21
                      TMC_STANDBY);                             // RULE5
   wire timer_exit = sleep_by_timer && prep_done && stb && ms_edge; // RULE16
   wire plain_exit = !sleep_by_timer && stb_rise;               // RULE14
   always_comb begin
      next_state = state;
      if (!sup) begin
         next_state = TMC_OFF;                                  // RULE1
      end else begin
         unique case (state)
            TMC_OFF:   next_state = TMC_STANDBY;
            TMC_SLEEP: begin
               if (any_wake) begin
                  next_state = TMC_STANDBY;                     // RULE20
               end else if (io_ok && (plain_exit || timer_exit)) begin
                  next_state = ms ? TMC_NORMAL : TMC_SILENT;    // RULE15
               end
            end
            default: begin
               if (uv_done || swe_done || gts_done) begin
                  next_state = sleep_tgt;                       // RULE11 RULE13
               end else if (io_lo) begin
                  next_state = TMC_STANDBY;
               end else if (pin_mode == TMC_SILENT &&
                            state == TMC_NORMAL) begin
                  next_state = TMC_SILENT;                      // RULE10
               end else begin
                  next_state = pin_mode;                        // RULE1
               end
            end
         endcase
      end
   end
   wire enter_normal = next_state == TMC_NORMAL && state != TMC_NORMAL;
   wire enter_sleep  = next_state == TMC_SLEEP && state != TMC_SLEEP;

   // state, sleep cause and flags; a wake in the clearing cycle survives
   always_ff @(posedge clock) begin
      if (!nrst) begin
         state               <= TMC_OFF;
         sleep_by_timer      <= 1'b0;
         wakeup_request_flag <= 1'b0;
         power_up_flag       <= 1'b0;
         wake_src            <= 2'h0;
      end else begin
         state <= next_state;
         if (enter_sleep) begin
            sleep_by_timer <= swe_done && !uv_done && !gts_done;
         end
         wakeup_request_flag <= any_wake |
                                (wakeup_request_flag & ~enter_normal); // RULE8
         power_up_flag <= (state == TMC_OFF && sup) |
                          (power_up_flag & ~enter_normal);     // RULE8
         if (any_wake) begin
            wake_src <= wake_src | {local_wake, bus_wake};
         end else if (state == TMC_NORMAL && next_state != TMC_NORMAL) begin
            wake_src <= 2'h0;
         end
      end
   end

   // ************************************************************
   // pin outputs, registered from the next mode
   // ************************************************************
   wire n_norm  = next_state == TMC_NORMAL;
   wire n_sil   = next_state == TMC_SILENT;
   wire n_awake = n_norm | n_sil;
   wire n_rx    = n_awake ? !bus_dom :
                  (next_state == TMC_OFF ? 1'b1 : !wake_pend);  // RULE6
   wire n_fault = n_norm ? ~(|wake_src | any_wake) :            // RULE7
                  n_sil  ? ~(power_up_flag | tsd) : 1'b1;       // RULE22
   wire n_pwr   = !(next_state inside {TMC_SLEEP, TMC_OFF});    // RULE19
   always_ff @(posedge clock) begin
      mode              <= nrst ? next_state : TMC_OFF;
      driver_enable     <= nrst & n_norm & ~tsd;                // RULE2
      receiver_enable   <= nrst & n_awake;                      // RULE3
      receive_out       <= ~nrst | n_rx;
      system_power_out  <= 1'b1;
      system_power_oe   <= nrst & n_pwr;                        // RULE5
      fault_indicator_n <= ~nrst | n_fault;
   end

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   a_normal_drive: assert property (next_state == TMC_NORMAL && // RULE2
      !tsd |=> driver_enable && receiver_enable && system_power_oe)
      else $error("normal mode outputs wrong");
   a_silent_drive: assert property (next_state == TMC_SILENT |=> // RULE3
      !driver_enable && receiver_enable)
      else $error("silent mode driver not off");
   a_gts_delay: assert property (state == TMC_GOTOSLEEP && // RULE4
      next_state == TMC_SLEEP |-> gts_cnt >= GTS_CYC || uv_done || swe_done)
      else $error("sleep entered before delay");
   a_standby_power: assert property (next_state == TMC_STANDBY |=> // RULE5
      system_power_oe && !receiver_enable && !driver_enable)
      else $error("standby outputs wrong");
   a_standby_rx: assert property (state == TMC_STANDBY && // RULE6
      next_state == TMC_STANDBY && wakeup_request_flag |=> !receive_out)
      else $error("pending wake not shown");
   a_normal_clear: assert property (enter_normal && !any_wake && // RULE8
      state != TMC_OFF |=> !wakeup_request_flag && !power_up_flag)
      else $error("flags not cleared");
   a_swe_reset: assert property (state == TMC_NORMAL |=> // RULE9
      swe_cnt == 32'h0 && !swe_run)
      else $error("expiry timer not reset");
   a_timer_sleep: assert property ($rose(state == TMC_SLEEP) && // RULE11
      sleep_by_timer |-> $past(swe_cnt) >= INACTIVE_CYC)
      else $error("timer sleep too early");
   a_uv_armed: assert property (!core_arm |-> core_cnt == 32'h0) // RULE12
      else $error("undervoltage timer ran unarmed");
   a_sleep_power: assert property (state == TMC_SLEEP |-> // RULE19
      !system_power_oe && !driver_enable && !receiver_enable)
      else $error("sleep outputs wrong");
   a_pin_exit_io: assert property (state == TMC_SLEEP && // RULE15
      next_state inside {TMC_NORMAL, TMC_SILENT} |-> io_ok)
      else $error("pin exit without io supply");
   a_wake_exit: assert property (state == TMC_SLEEP && any_wake && // RULE20
      sup |=> state == TMC_STANDBY)
      else $error("wake did not leave sleep");

   c_normal: cover property (state == TMC_STANDBY ##1 state == TMC_NORMAL);
   c_gts_sleep: cover property (state == TMC_GOTOSLEEP ##1 state == TMC_SLEEP);
   c_timer_sleep: cover property (sleep_by_timer && state == TMC_SLEEP
      ##[1:1000] state == TMC_NORMAL);
   c_bus_wake: cover property (bus_wake && state == TMC_SLEEP);
endmodule // tmc_mode_ctrl
`default_nettype wire

// ### verilog/tmc_params.svh
`ifndef TMC_PARAMS_SVH
`define TMC_PARAMS_SVH
// ************************************************************
// register map and field positions
// ************************************************************
`define TMC_ADDR_W          4
`define TMC_OFS_CONFIG      4'h0
`define TMC_OFS_STATUS      4'h4
`define TMC_CFG_BUS_WAKE_EN 0
`define TMC_CFG_LOC_WAKE_EN 1
`define TMC_CFG_RESET       2'h3
`define TMC_ST_MODE_LSB     0
`define TMC_ST_WAKE_FLAG    4
`define TMC_ST_PWR_FLAG     5
`define TMC_ST_SRC_BUS      6
`define TMC_ST_SRC_LOC      7
`define TMC_ST_TIMER_SLEEP  8
// ************************************************************
// timing, in microseconds, and derived counts at 40 MHz
// ************************************************************
`define TMC_CLK_NS          64'd25
`define TMC_GTS_US          64'd50
`define TMC_UV_US           64'd200000
`define TMC_INACTIVE_US     64'd4000000
`define TMC_HOLD_US         64'd10
`define TMC_WK_FILT_US      64'd1
`define TMC_WK_TMO_US       64'd1000
`define TMC_CYC_UP(us)  (((us) * 64'd1000 + `TMC_CLK_NS - 64'd1) / `TMC_CLK_NS)
`define TMC_CYC_DN(us)  (((us) * 64'd1000) / `TMC_CLK_NS)
`define TMC_GTS_CYC         `TMC_CYC_UP(`TMC_GTS_US)
`define TMC_UV_CYC          `TMC_CYC_UP(`TMC_UV_US)
`define TMC_INACTIVE_CYC    `TMC_CYC_UP(`TMC_INACTIVE_US)
`define TMC_HOLD_CYC        `TMC_CYC_UP(`TMC_HOLD_US)
`define TMC_WK_FILT_CYC     `TMC_CYC_UP(`TMC_WK_FILT_US)
`define TMC_WK_TMO_CYC      `TMC_CYC_DN(`TMC_WK_TMO_US)
`endif

// ### verilog/tmc_pkg.sv
`default_nettype none
package tmc_pkg;
   // operating modes of the transceiver
   typedef enum logic [2:0] {
      TMC_OFF, TMC_NORMAL, TMC_SILENT, TMC_STANDBY, TMC_GOTOSLEEP, TMC_SLEEP
   } tmc_mode_t;
   // progress through the bus wake sequence
   typedef enum logic [1:0] {
      TMC_WK_IDLE, TMC_WK_REC, TMC_WK_DOM2
   } tmc_wake_t;
endpackage
`default_nettype wire

// ### dv/tmc_host_model.sv
`default_nettype none
module tmc_host_model #(
   parameter int unsigned HOLD_CYC = 10
) (
   input  wire logic clock,            // shared clock
   output var  logic mode_select,      // select pin to the device
   output var  logic standby_select_n  // standby pin to the device
);
   timeunit 1ns;
   timeprecision 1ps;
   // ************************************************************
   // controller pin requests
   // ************************************************************
   // both pins start low: the device comes up in standby
   initial begin
      mode_select = 1'b0;
      standby_select_n = 1'b0;
   end
   // pins change just after an edge and hold until the next request
   task automatic pins(input logic ms, input logic stb);
      @(posedge clock);
      mode_select      <= ms;
      standby_select_n <= stb;
   endtask
   // timer sleep exit up to the final select edge, which the caller makes
   task automatic timer_prep(input logic last_ms);
      pins(last_ms, 1'b0);
      pins(!last_ms, 1'b0);
      repeat (HOLD_CYC + 4) @(posedge clock);
      pins(!last_ms, 1'b1);
      repeat (6) @(posedge clock);   // a bare rise must not wake
   endtask
endmodule // tmc_host_model
`default_nettype wire

// ### dv/testbench.sv
`include "tmc_params.svh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import tmc_pkg::*;
   // short counts keep the run brief
   localparam int GTS = 20;
   localparam int UV = 50;
   localparam int INA = 200;
   localparam int FILT = 4;
   logic clock = 1'b0, nrst = 1'b0, bus_dom = 1'b0, local_pin = 1'b0;
   logic supply_ok = 1'b1, core_rise = 1'b0, core_fall = 1'b1;
   logic io_rise = 1'b1, io_fall = 1'b0, over_temp = 1'b0;
   logic reg_wr = 1'b0, reg_rd = 1'b0;
   logic [`TMC_ADDR_W-1:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0, reg_rdata, rdv;
   wire logic ms, stb;
   tmc_mode_t mode;
   logic drv_en, rcv_en, rx_out, pwr_out, pwr_oe, fault_n, wk_flag, pu_flag;
   int checked = 0, bad_count = 0;
   // ************************************************************
   // device, controller model and clock
   // ************************************************************
   tmc_mode_ctrl #(.GTS_CYC(GTS), .UV_CYC(UV), .INACTIVE_CYC(INA),
      .HOLD_CYC(10), .WK_FILT_CYC(FILT), .WK_TMO_CYC(100)) u_dut (
      .clock(clock), .nrst(nrst), .mode_select(ms), .standby_select_n(stb),
      .bus_dominant(bus_dom), .local_trigger_pin(local_pin),
      .supply_ok(supply_ok), .core_above_rise(core_rise),
      .core_below_fall(core_fall), .io_above_rise(io_rise),
      .io_below_fall(io_fall), .over_temp(over_temp), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .mode(mode), .driver_enable(drv_en),
      .receiver_enable(rcv_en), .receive_out(rx_out),
      .system_power_out(pwr_out), .system_power_oe(pwr_oe),
      .fault_indicator_n(fault_n), .wakeup_request_flag(wk_flag),
      .power_up_flag(pu_flag));
   tmc_host_model #(.HOLD_CYC(10)) u_host (.clock(clock), .mode_select(ms),
      .standby_select_n(stb));
   initial begin
      forever #12.5 clock = ~clock;
   end
   // ************************************************************
   // tasks
   // ************************************************************
   task automatic close_out;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // settle past the edge so sampling never races the design
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // bounded wait; a stuck mode ends the run
   task automatic wait_mode(input tmc_mode_t m, input int n);
      for (int i = 0; i < n && mode !== m; i++) cyc(1);
      chk("mode", 32'(mode), 32'(m));
      if (mode !== m) close_out();
   endtask
   task automatic rd(input logic [`TMC_ADDR_W-1:0] a);
      @(posedge clock);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 rdv = reg_rdata;
   endtask
   // one-cycle write strobe beside address and data
   task automatic wr(input logic [`TMC_ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   // dominant, recessive, dominant, each past the filter
   task automatic bus_wup;
      for (int i = 0; i < 3; i++) begin
         @(posedge clock) bus_dom <= (i != 1);
         cyc(FILT + 3);
      end
      @(posedge clock) bus_dom <= 1'b0;
   endtask
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      cyc(5);
      chk("mode", 32'(mode), 32'(TMC_OFF));
      @(posedge clock) nrst <= 1'b1;
      wait_mode(TMC_STANDBY, 10);
      chk("pwr", {pwr_out, pwr_oe}, 32'h3);
      chk("rcv_en", 32'(rcv_en | drv_en), 32'h0);
      chk("pu_flag", 32'(pu_flag), 32'h1);
      rd(`TMC_OFS_CONFIG);
      chk("config", rdv, 32'h3);
      wr(`TMC_OFS_STATUS, '1);
      rd(`TMC_OFS_STATUS);
      chk("status", rdv[5:0], 32'h23);
      wr(`TMC_OFS_CONFIG, 32'h1);
      rd(`TMC_OFS_CONFIG);
      chk("config", rdv, 32'h1);
      wr(`TMC_OFS_CONFIG, 32'h3);
      rd(4'h8);
      chk("unmapped", rdv, 32'h0);
      cyc(70);
      chk("mode", 32'(mode), 32'(TMC_STANDBY));
      @(posedge clock) core_rise <= 1'b1;
      core_fall <= 1'b0;
      u_host.pins(1'b1, 1'b1);
      wait_mode(TMC_NORMAL, 8);
      chk("en", {drv_en, rcv_en, pwr_oe, pu_flag}, 32'he);
      @(posedge clock) bus_dom <= 1'b1;
      cyc(5);
      chk("rx_out", 32'(rx_out), 32'h0);
      @(posedge clock) bus_dom <= 1'b0;
      u_host.pins(1'b0, 1'b1);
      wait_mode(TMC_SILENT, 8);
      chk("en", {drv_en, rcv_en, fault_n}, 32'h3);
      @(posedge clock) over_temp <= 1'b1;
      cyc(5);
      chk("fault_n", 32'(fault_n), 32'h0);
      @(posedge clock) over_temp <= 1'b0;
      cyc(INA + 20);
      chk("mode", 32'(mode), 32'(TMC_SILENT));
      u_host.pins(1'b0, 1'b0);
      wait_mode(TMC_STANDBY, 8);
      chk("rx_out", 32'(rx_out), 32'h1);
      cyc(INA - 20);
      chk("mode", 32'(mode), 32'(TMC_STANDBY));
      wait_mode(TMC_SLEEP, 40);
      chk("en", {drv_en, rcv_en, pwr_oe}, 32'h0);
      rd(`TMC_OFS_STATUS);
      chk("timer_src", 32'(rdv[8]), 32'h1);
      u_host.timer_prep(1'b1);
      chk("mode", 32'(mode), 32'(TMC_SLEEP));
      u_host.pins(1'b1, 1'b1);
      wait_mode(TMC_NORMAL, 8);
      u_host.pins(1'b0, 1'b0);
      cyc(INA / 2);
      u_host.pins(1'b0, 1'b1);
      wait_mode(TMC_SILENT, 8);
      wait_mode(TMC_SLEEP, INA / 2 + 20);
      u_host.timer_prep(1'b0);
      u_host.pins(1'b0, 1'b1);
      wait_mode(TMC_SILENT, 8);
      u_host.pins(1'b1, 1'b0);
      wait_mode(TMC_GOTOSLEEP, 8);
      cyc(GTS - 6);
      chk("gts", {3'(mode), pwr_oe}, 32'h9);
      wait_mode(TMC_SLEEP, 12);
      chk("pwr_oe", 32'(pwr_oe), 32'h0);
      @(posedge clock) io_rise <= 1'b0;
      u_host.pins(1'b0, 1'b1);
      cyc(8);
      chk("mode", 32'(mode), 32'(TMC_SLEEP));
      u_host.pins(1'b0, 1'b0);
      @(posedge clock) io_rise <= 1'b1;
      cyc(4);
      u_host.pins(1'b0, 1'b1);
      wait_mode(TMC_SILENT, 8);
      // two local edges, then a bus pattern, each from sleep
      for (int k = 0; k < 3; k++) begin
         u_host.pins(1'b1, 1'b1);
         wait_mode(TMC_NORMAL, 8);
         u_host.pins(1'b1, 1'b0);
         wait_mode(TMC_SLEEP, GTS + 12);
         if (k < 2) begin
            @(posedge clock) local_pin <= !local_pin;
         end else begin
            bus_wup();
         end
         wait_mode(TMC_STANDBY, 12);
         chk("wake", {wk_flag, rx_out}, 32'h2);
         cyc(GTS + 10);
         chk("mode", 32'(mode), 32'(TMC_STANDBY));
         u_host.pins(1'b1, 1'b1);
         wait_mode(TMC_NORMAL, 8);
         chk("flag_fault", {wk_flag, fault_n}, 32'h0);
         rd(`TMC_OFS_STATUS);
         chk("src", 32'(rdv[7:6]), (k < 2) ? 32'h2 : 32'h1);
      end
      @(posedge clock) io_fall <= 1'b1;
      wait_mode(TMC_STANDBY, 8);
      wait_mode(TMC_SLEEP, UV + 20);
      @(posedge clock) io_fall <= 1'b0;
      u_host.pins(1'b1, 1'b0);
      cyc(4);
      u_host.pins(1'b1, 1'b1);
      wait_mode(TMC_NORMAL, 8);
      @(posedge clock) supply_ok <= 1'b0;
      wait_mode(TMC_OFF, 8);
      chk("pwr_oe", 32'(pwr_oe), 32'h0);
      close_out();
   end
endmodule // testbench
`default_nettype wire
